// file: rtl/dasc_regs.svh
// field positions, codes, reset values and timing counts of the diagnostic converter sequencer
`ifndef DASC_REGS_SVH
`define DASC_REGS_SVH

// monitor_converter_setup word layout
`define DASC_SETUP_WIDTH      16
`define DASC_CMD_MSB          10
`define DASC_CMD_LSB          8
`define DASC_ARG_MSB          7
`define DASC_ARG_LSB          5
`define DASC_SEL_MSB          4
`define DASC_SEL_LSB          0
`define DASC_ARG_ENABLE_BIT   0

// command codes
`define DASC_CMD_DEPTH        3'h0
`define DASC_CMD_LOAD         3'h1
`define DASC_CMD_KEY_SEQ      3'h2
`define DASC_CMD_AUTO_SEQ     3'h3
`define DASC_CMD_SINGLE       3'h4
`define DASC_CMD_ARM_KEY      3'h5

// key register value that triggers a conversion
`define DASC_KEY_CONV         16'h1ADC

// reset values
`define DASC_SLOT_RESET       5'h00
`define DASC_DEPTH_RESET      3'h0
`define DASC_RESULT_RESET     12'h000

// sizes
`define DASC_MAX_DEPTH        8
`define DASC_RESULT_WIDTH     12
`define DASC_SEL_WIDTH        5
`define DASC_READBACK_WIDTH   18

// timing: converter latency in ns at the system clock period
`define DASC_CLK_PERIOD_NS    10
`define DASC_CONV_TIME_NS     1000
`define DASC_CNT_WIDTH        16

`endif

// file: rtl/dasc_pkg.sv
// types shared by the diagnostic converter sequencer modules
`include "dasc_regs.svh"

package dasc_pkg;

    typedef enum logic [2:0] {
        DASC_CMD_DEPTH_E    = `DASC_CMD_DEPTH,
        DASC_CMD_LOAD_E     = `DASC_CMD_LOAD,
        DASC_CMD_KEY_SEQ_E  = `DASC_CMD_KEY_SEQ,
        DASC_CMD_AUTO_SEQ_E = `DASC_CMD_AUTO_SEQ,
        DASC_CMD_SINGLE_E   = `DASC_CMD_SINGLE,
        DASC_CMD_ARM_KEY_E  = `DASC_CMD_ARM_KEY
    } dasc_cmd_e;

    // gray path idle -> busy -> idle
    typedef enum logic [0:0] {
        DASC_CV_IDLE = 1'b0,
        DASC_CV_BUSY = 1'b1
    } dasc_cv_state_e;

    typedef struct packed {
        dasc_cv_state_e                  state;
        logic [`DASC_CNT_WIDTH-1:0]      cnt;
        logic                            busy;
        logic                            done;
        logic [`DASC_SEL_WIDTH-1:0]      sel;
        logic [`DASC_RESULT_WIDTH-1:0]   result;
    } dasc_conv_s;

    typedef struct packed {
        logic [2:0]                                          depth;
        logic [`DASC_MAX_DEPTH-1:0][`DASC_SEL_WIDTH-1:0]     slots;
        logic [2:0]                                          ptr;
        logic                                                key_en;
        logic                                                auto_en;
        logic                                                armed;
        logic [`DASC_SEL_WIDTH-1:0]                          armed_sel;
        logic                                                conv_seq;
        logic [`DASC_RESULT_WIDTH-1:0]                       res;
        logic [`DASC_SEL_WIDTH-1:0]                          res_sel;
        logic [`DASC_READBACK_WIDTH-1:0]                     readback;
    } dasc_ctrl_s;

endpackage : dasc_pkg

// file: rtl/dasc_conv.sv
// converter latency model: holds busy for a fixed count, captures the code as busy falls
`timescale 1ns/1ps
`default_nettype none
`include "dasc_regs.svh"

module dasc_conv #(
    parameter int unsigned CONV_CYCLES = `DASC_CONV_TIME_NS / `DASC_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_rstn,
    input  wire logic                           i_clk_en,
    // start request
    input  wire logic                           i_start,
    input  wire logic [`DASC_SEL_WIDTH-1:0]     i_sel,
    // analog front end code
    input  wire logic [`DASC_RESULT_WIDTH-1:0]  i_sample,
    // conversion state
    output logic                                o_busy,
    output logic                                o_done,
    output logic [`DASC_SEL_WIDTH-1:0]          o_sel,
    output logic [`DASC_RESULT_WIDTH-1:0]       o_result
);

    // a zero count would give no busy window; clamp to one cycle
    localparam logic [`DASC_CNT_WIDTH-1:0] LOAD_CNT =
        (CONV_CYCLES > 1) ? `DASC_CNT_WIDTH'(CONV_CYCLES - 1) : '0;

    dasc_pkg::dasc_conv_s q_r;
    dasc_pkg::dasc_conv_s q_nxt;

    always_comb begin
        q_nxt      = q_r;
        q_nxt.done = 1'b0;
        case (q_r.state)
            dasc_pkg::DASC_CV_IDLE: begin
                if (i_start) begin
                    q_nxt.state = dasc_pkg::DASC_CV_BUSY;
                    q_nxt.busy  = 1'b1;
                    q_nxt.cnt   = LOAD_CNT;
                    q_nxt.sel   = i_sel;
                end
            end
            dasc_pkg::DASC_CV_BUSY: begin
                if (q_r.cnt == '0) begin
                    q_nxt.state  = dasc_pkg::DASC_CV_IDLE;
                    q_nxt.busy   = 1'b0;
                    q_nxt.done   = 1'b1;
                    q_nxt.result = i_sample;
                end else begin
                    q_nxt.cnt = q_r.cnt - 1'b1;
                end
            end
            default: begin
                q_nxt.state = dasc_pkg::DASC_CV_IDLE;
                q_nxt.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q_r <= '{state: dasc_pkg::DASC_CV_IDLE, cnt: '0, busy: 1'b0, done: 1'b0,
                     sel: `DASC_SLOT_RESET, result: `DASC_RESULT_RESET};
        end else if (i_clk_en) begin
            q_r <= q_nxt;
        end
    end

    assign o_busy   = q_r.busy;
    assign o_done   = q_r.done;
    assign o_sel    = q_r.sel;
    assign o_result = q_r.result;

endmodule // dasc_conv

`default_nettype wire

// file: rtl/dasc_seq_ctrl.sv
// diagnostic converter sequencer control: setup decode, sequencing, key triggers, status
`timescale 1ns/1ps
`default_nettype none
`include "dasc_regs.svh"

module dasc_seq_ctrl #(
    parameter int unsigned CONV_CYCLES = `DASC_CONV_TIME_NS / `DASC_CLK_PERIOD_NS
) (
    // clock, reset and clock enable
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_rstn,
    input  wire logic                              i_clk_en,
    // monitor_converter_setup write from the serial frame decoder
    input  wire logic                              i_cfg_wr,
    input  wire logic [`DASC_SETUP_WIDTH-1:0]      i_cfg_data,
    // key register write from the serial frame decoder
    input  wire logic                              i_key_wr,
    input  wire logic [`DASC_SETUP_WIDTH-1:0]      i_key_data,
    // serial frame events
    input  wire logic                              i_frame_start,
    input  wire logic                              i_frame_valid,
    // code from the analog converter front end
    input  wire logic [`DASC_RESULT_WIDTH-1:0]     i_conv_code,
    // converter state
    output logic                                   o_conv_busy,
    output logic [`DASC_SEL_WIDTH-1:0]             o_conv_input_selector,
    // status: latest completed result and its input code
    output logic [`DASC_RESULT_WIDTH-1:0]          o_result,
    output logic [`DASC_SEL_WIDTH-1:0]             o_result_selector,
    // status word captured at each frame start: busy, code, result
    output logic [`DASC_READBACK_WIDTH-1:0]        o_readback,
    // sequencer state
    output logic [2:0]                             o_depth,
    output logic [2:0]                             o_seq_ptr,
    output logic                                   o_key_seq_en,
    output logic                                   o_auto_seq_en,
    output logic                                   o_single_armed
);

    dasc_pkg::dasc_ctrl_s q_r;
    dasc_pkg::dasc_ctrl_s q_nxt;

    // setup word fields
    dasc_pkg::dasc_cmd_e                cfg_cmd;
    logic [2:0]                         cfg_arg;
    logic [`DASC_SEL_WIDTH-1:0]         cfg_sel;
    logic                               cfg_enable;

    // converter handshake
    logic                               start;
    logic [`DASC_SEL_WIDTH-1:0]         start_sel;
    logic                               start_seq;
    logic                               conv_busy;
    logic                               conv_done;
    logic [`DASC_SEL_WIDTH-1:0]         conv_sel;
    logic [`DASC_RESULT_WIDTH-1:0]      conv_result;

    // trigger qualifiers
    logic                               key_hit;
    logic                               cfg_single;

    assign cfg_cmd    = dasc_pkg::dasc_cmd_e'(i_cfg_data[`DASC_CMD_MSB:`DASC_CMD_LSB]);
    assign cfg_arg    = i_cfg_data[`DASC_ARG_MSB:`DASC_ARG_LSB];
    assign cfg_sel    = i_cfg_data[`DASC_SEL_MSB:`DASC_SEL_LSB];
    assign cfg_enable = cfg_arg[`DASC_ARG_ENABLE_BIT];

    assign key_hit    = i_key_wr && (i_key_data == `DASC_KEY_CONV);
    assign cfg_single = i_cfg_wr && (cfg_cmd == dasc_pkg::DASC_CMD_SINGLE_E);

    always_comb begin
        q_nxt     = q_r;
        start     = 1'b0;
        start_sel = `DASC_SLOT_RESET;
        start_seq = 1'b0;

        // completion first, so a restart decoded below in the same cycle wins
        if (conv_done) begin
            q_nxt.res     = conv_result;
            q_nxt.res_sel = conv_sel;
            if (q_r.conv_seq && (q_r.key_en || q_r.auto_en)) begin
                // pointer moves only once the converted channel is finished
                if (q_r.ptr == q_r.depth) begin
                    q_nxt.ptr = 3'h0;
                end else begin
                    q_nxt.ptr = q_r.ptr + 3'h1;
                end
            end
        end

        // setup word decode
        if (i_cfg_wr) begin
            case (cfg_cmd)
                dasc_pkg::DASC_CMD_DEPTH_E: begin
                    q_nxt.depth = cfg_arg;
                end
                dasc_pkg::DASC_CMD_LOAD_E: begin
                    q_nxt.slots[cfg_arg] = cfg_sel;
                end
                dasc_pkg::DASC_CMD_KEY_SEQ_E: begin
                    if (cfg_enable) begin
                        if (!q_r.key_en) begin
                            q_nxt.ptr = 3'h0;
                        end
                        q_nxt.key_en  = 1'b1;
                        q_nxt.auto_en = 1'b0;
                    end else begin
                        q_nxt.key_en = 1'b0;
                    end
                end
                dasc_pkg::DASC_CMD_AUTO_SEQ_E: begin
                    if (cfg_enable) begin
                        if (!q_r.auto_en) begin
                            q_nxt.ptr = 3'h0;
                        end
                        q_nxt.auto_en = 1'b1;
                        q_nxt.key_en  = 1'b0;
                    end else begin
                        q_nxt.auto_en = 1'b0;
                    end
                end
                dasc_pkg::DASC_CMD_SINGLE_E: begin
                    // depth and slots stay; only the running automatic mode stops
                    q_nxt.auto_en = 1'b0;
                    if (!conv_busy) begin
                        start     = 1'b1;
                        start_sel = cfg_sel;
                    end
                end
                dasc_pkg::DASC_CMD_ARM_KEY_E: begin
                    q_nxt.armed     = 1'b1;
                    q_nxt.armed_sel = cfg_sel;
                end
                default: begin
                    q_nxt.depth = q_r.depth;
                end
            endcase
        end

        // key register trigger: sequence step in key mode, else the armed single
        if (key_hit && !conv_busy && !start) begin
            if (q_r.key_en) begin
                start     = 1'b1;
                start_sel = q_r.slots[q_r.ptr];
                start_seq = 1'b1;
            end else if (q_r.armed) begin
                start       = 1'b1;
                start_sel   = q_r.armed_sel;
                // a fresh arm in the same cycle wins over the clear
                q_nxt.armed = i_cfg_wr && (cfg_cmd == dasc_pkg::DASC_CMD_ARM_KEY_E);
            end
        end

        // frame trigger: the enabling frame itself sees the old mode and does not convert
        if (i_frame_valid && q_r.auto_en && q_nxt.auto_en && !cfg_single
            && !conv_busy && !start) begin
            start     = 1'b1;
            start_sel = q_r.slots[q_r.ptr];
            start_seq = 1'b1;
        end

        if (start) begin
            q_nxt.conv_seq = start_seq;
        end

        // status word for the frame now starting: busy, code, last completed result
        if (i_frame_start) begin
            q_nxt.readback = {conv_busy, q_r.res_sel, q_r.res};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q_r.depth     <= `DASC_DEPTH_RESET;
            q_r.slots     <= {`DASC_MAX_DEPTH{`DASC_SLOT_RESET}};
            q_r.ptr       <= 3'h0;
            q_r.key_en    <= 1'b0;
            q_r.auto_en   <= 1'b0;
            q_r.armed     <= 1'b0;
            q_r.armed_sel <= `DASC_SLOT_RESET;
            q_r.conv_seq  <= 1'b0;
            q_r.res       <= `DASC_RESULT_RESET;
            q_r.res_sel   <= `DASC_SLOT_RESET;
            q_r.readback  <= '0;
        end else if (i_clk_en) begin
            q_r <= q_nxt;
        end
    end

    // latency model of the analog converter
    dasc_conv #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_conv (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_clk_en  (i_clk_en),
        .i_start   (start),
        .i_sel     (start_sel),
        .i_sample  (i_conv_code),
        .o_busy    (conv_busy),
        .o_done    (conv_done),
        .o_sel     (conv_sel),
        .o_result  (conv_result)
    );

    // all outputs are flops, here or in the converter model
    assign o_conv_busy           = conv_busy;
    assign o_conv_input_selector = conv_sel;
    assign o_result              = q_r.res;
    assign o_result_selector     = q_r.res_sel;
    assign o_readback            = q_r.readback;
    assign o_depth               = q_r.depth;
    assign o_seq_ptr             = q_r.ptr;
    assign o_key_seq_en          = q_r.key_en;
    assign o_auto_seq_en         = q_r.auto_en;
    assign o_single_armed        = q_r.armed;

endmodule // dasc_seq_ctrl

`default_nettype wire

// file: tb/dasc_seq_ctrl_properties.sv
// port-level assertions of the diagnostic converter sequencer control
`timescale 1ns/1ps
`default_nettype none
`include "dasc_regs.svh"
module dasc_seq_props #(
    parameter int unsigned CONV_CYCLES = 4
) (
    // clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rstn,
    // host strobes
    input wire logic        i_cfg_wr,
    input wire logic [15:0] i_cfg_data,
    input wire logic        i_key_wr,
    input wire logic [15:0] i_key_data,
    input wire logic        i_frame_start,
    input wire logic        i_frame_valid,
    input wire logic [11:0] i_conv_code,
    // design state
    input wire logic        o_conv_busy,
    input wire logic [4:0]  o_conv_input_selector,
    input wire logic [11:0] o_result,
    input wire logic [4:0]  o_result_selector,
    input wire logic [17:0] o_readback,
    input wire logic [2:0]  o_depth,
    input wire logic [2:0]  o_seq_ptr,
    input wire logic        o_key_seq_en,
    input wire logic        o_auto_seq_en,
    input wire logic        o_single_armed
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    logic [15:0] busy_len_r;
    logic [2:0]  cmd, arg;
    logic [4:0]  sel;
    logic        key_hit;
    assign cmd = i_cfg_data[10:8];
    assign arg = i_cfg_data[7:5];
    assign sel = i_cfg_data[4:0];
    assign key_hit = i_key_wr && i_key_data == `DASC_KEY_CONV;
    // busy run length, judged where busy falls
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_len_r <= 16'h0000;
        end else begin
            busy_len_r <= o_conv_busy ? busy_len_r + 16'h0001 : 16'h0000;
        end
    end
    sequence s_done;
        $fell(o_conv_busy);
    endsequence
    sequence s_start_req;
        i_frame_valid || key_hit || (i_cfg_wr && cmd == 3'h4);
    endsequence
    a_busy_len_fixed: assert property (s_done |-> busy_len_r == 16'(CONV_CYCLES))
        else $error("busy run length wrong");
    a_result_capture: assert property (s_done |=> o_result == $past(i_conv_code, 2)
        && o_result_selector == $past(o_conv_input_selector)) else $error("result not captured");
    a_busy_ignores: assert property (o_conv_busy ##0 s_start_req |=> $stable(o_conv_input_selector))
        else $error("start taken while busy");
    a_readback_snap: assert property (i_frame_start |=> o_readback ==
        {$past(o_conv_busy), $past(o_result_selector), $past(o_result)}) else $error("readback wrong");
    a_modes_exclusive: assert property (!(o_key_seq_en && o_auto_seq_en))
        else $error("both sequencing modes on");
    a_key_restart: assert property (i_cfg_wr && cmd == 3'h2 && arg[0] && !o_key_seq_en
        |=> o_key_seq_en && !o_auto_seq_en && o_seq_ptr == 3'h0) else $error("key enable wrong");
    a_auto_restart: assert property (i_cfg_wr && cmd == 3'h3 && arg[0] && !o_auto_seq_en
        |=> o_auto_seq_en && !o_key_seq_en && o_seq_ptr == 3'h0) else $error("auto enable wrong");
    a_depth_store: assert property (i_cfg_wr && cmd == 3'h0 |=> o_depth == $past(arg))
        else $error("depth not stored");
    a_single_start: assert property (i_cfg_wr && cmd == 3'h4 |=> !o_auto_seq_en && ($past(o_conv_busy)
        || (o_conv_busy && o_conv_input_selector == $past(sel)))) else $error("single start wrong");
    a_ptr_advance: assert property (s_done ##0 (o_key_seq_en || o_auto_seq_en) ##0 !i_cfg_wr
        |=> o_seq_ptr == (($past(o_seq_ptr) == $past(o_depth)) ? 3'h0 : $past(o_seq_ptr) + 3'h1))
        else $error("pointer step wrong");
    a_armed_fire: assert property (o_single_armed && !o_key_seq_en && !o_conv_busy && key_hit
        && !i_cfg_wr |=> o_conv_busy && !o_single_armed) else $error("armed key conversion wrong");
endmodule // dasc_seq_props
bind dasc_seq_ctrl dasc_seq_props #(.CONV_CYCLES(CONV_CYCLES)) dasc_seq_props_inst (
    .i_sys_clk, .i_rstn, .i_cfg_wr, .i_cfg_data, .i_key_wr, .i_key_data, .i_frame_start,
    .i_frame_valid, .i_conv_code, .o_conv_busy, .o_conv_input_selector, .o_result,
    .o_result_selector, .o_readback, .o_depth, .o_seq_ptr, .o_key_seq_en, .o_auto_seq_en,
    .o_single_armed
);
`default_nettype wire

// file: tb/dasc_host_model.sv
// serial host model: frames carrying a setup word, a key write, nothing, or a bad frame
`timescale 1ns/1ps
`default_nettype none
module dasc_host_model (
    // clock
    input  wire logic   i_sys_clk,
    // decoded frame strobes
    output logic        o_cfg_wr,
    output logic [15:0] o_cfg_data,
    output logic        o_key_wr,
    output logic [15:0] o_key_data,
    output logic        o_frame_start,
    output logic        o_frame_valid
);
    initial begin
        {o_cfg_wr, o_key_wr, o_frame_start, o_frame_valid} = 4'h0;
        o_cfg_data = 16'h0000;
        o_key_data = 16'h0000;
    end
    // kind 0 empty, 1 setup, 2 key, 3 bad; gap models a slow host
    task automatic frame(input logic [1:0] kind, input logic [15:0] word, input int gap);
        @(posedge i_sys_clk);
        #1;
        o_frame_start = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_frame_start = 1'b0;
        repeat (gap) @(posedge i_sys_clk);
        #1;
        o_frame_valid = (kind != 2'd3);
        o_cfg_wr = (kind == 2'd1);
        o_key_wr = (kind == 2'd2);
        o_cfg_data = word;
        o_key_data = word;
        @(posedge i_sys_clk);
        #1;
        {o_cfg_wr, o_key_wr, o_frame_valid} = 3'h0;
        // released words no longer hold the last value
        o_cfg_data = ~o_cfg_data;
        o_key_data = ~o_key_data;
    endtask
endmodule // dasc_host_model
`default_nettype wire

// file: tb/dasc_seq_ctrl_bench.sv
// self-checking bench of the diagnostic converter sequencer control
`timescale 1ns/1ps
`default_nettype none
`include "dasc_regs.svh"
module dasc_seq_ctrl_bench;
    localparam int unsigned CONV = 4;
    localparam logic [15:0] KEY = `DASC_KEY_CONV;
    logic        i_sys_clk, i_rstn, cfg_wr, key_wr, fs, fv, busy, ken, aen, armed;
    logic [15:0] cfg_data, key_data;
    logic [11:0] code, res, last_res;
    logic [4:0]  csel, rsel, last_sel, s;
    logic [17:0] rb;
    logic [2:0]  depth, ptr;
    logic [31:0] seed;
    logic [4:0]  slots [8];
    int          n_errors, tests_run, cycles;
    dasc_host_model dasc_host_model_inst (.i_sys_clk(i_sys_clk), .o_cfg_wr(cfg_wr),
        .o_cfg_data(cfg_data), .o_key_wr(key_wr), .o_key_data(key_data),
        .o_frame_start(fs), .o_frame_valid(fv));
    dasc_seq_ctrl #(.CONV_CYCLES(CONV)) dasc_seq_ctrl_inst (.i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn), .i_clk_en(1'b1), .i_cfg_wr(cfg_wr), .i_cfg_data(cfg_data),
        .i_key_wr(key_wr), .i_key_data(key_data), .i_frame_start(fs), .i_frame_valid(fv),
        .i_conv_code(code), .o_conv_busy(busy), .o_conv_input_selector(csel), .o_result(res),
        .o_result_selector(rsel), .o_readback(rb), .o_depth(depth), .o_seq_ptr(ptr),
        .o_key_seq_en(ken), .o_auto_seq_en(aen), .o_single_armed(armed));
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [15:0] w(input logic [2:0] c, a, input logic [4:0] v);
        return {5'h00, c, a, v};
    endfunction
    function automatic logic [2:0] nxt(input logic [2:0] p, d);
        return (p == d) ? 3'h0 : p + 3'h1;
    endfunction
    task automatic chk(input string what, input logic [47:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic fr(input logic [1:0] kind, input logic [15:0] word);
        seed = xs(seed);
        dasc_host_model_inst.frame(kind, word, int'(seed[1:0]));
    endtask
    // wait for the conversion in flight, then compare the status it left
    task automatic done(input logic [4:0] v);
        int n;
        n = 0;
        chk("busy at start", busy, 1'b1);
        while (busy !== 1'b0 && n < 40) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        @(posedge i_sys_clk);
        #1;
        chk("result", res, code);
        chk("result code", rsel, v);
        last_res = code;
        last_sel = v;
        seed = xs(seed);
        code = seed[11:0];
    endtask
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        {n_errors, tests_run, cycles} = 0;
        seed = 32'h2888_015c;
        {code, last_res, last_sel} = 0;
        i_rstn = 1'b0;
        repeat (20) @(posedge i_sys_clk);
        #1;
        i_rstn = 1'b1;
        @(posedge i_sys_clk);
        #1;
        chk("reset", {rb, res, rsel, depth, ptr, ken, aen, armed, busy}, 0);
        for (int d = 7; d >= 0; d--) begin
            fr(2'd1, w(3'h0, d[2:0], 5'h00));
            chk("depth", depth, d[2:0]);
        end
        fr(2'd1, w(3'h6, 3'h1, 5'h03));
        fr(2'd1, w(3'h7, 3'h1, 5'h03));
        chk("unused codes", {depth, ken, aen, armed, busy}, 0);
        // host sets depth 2 and slots 0 to 2 before enabling; regulator nodes would use key mode
        fr(2'd1, w(3'h0, 3'h2, 5'h00));
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            slots[i] = seed[4:0];
            fr(2'd1, w(3'h1, i[2:0], slots[i]));
        end
        fr(2'd1, w(3'h2, 3'h1, 5'h00));
        chk("key mode", {ken, aen, ptr}, 5'b10000);
        fr(2'd2, KEY ^ 16'h0001);
        chk("wrong key", busy, 1'b0);
        for (int i = 0; i < 4; i++) begin
            fr(2'd2, KEY);
            dasc_host_model_inst.frame(2'd2, KEY, 0);
            chk("readback busy", rb, {1'b1, last_sel, last_res});
            done(slots[i % 3]);
            chk("pointer", ptr, nxt(3'(i % 3), 3'h2));
        end
        fr(2'd0, 16'h0000);
        chk("readback idle", rb, {1'b0, last_sel, last_res});
        fr(2'd1, w(3'h3, 3'h1, 5'h00));
        chk("auto mode", {ken, aen, ptr, busy}, 6'b010000);
        for (int i = 0; i < 4; i++) begin
            fr(2'd0, 16'h0000);
            done(slots[i % 3]);
        end
        fr(2'd3, 16'h0000);
        chk("bad frame", busy, 1'b0);
        fr(2'd1, w(3'h3, 3'h0, 5'h00));
        fr(2'd1, w(3'h2, 3'h1, 5'h00));
        chk("key again", {ken, aen, ptr, depth}, 8'b10000010);
        fr(2'd2, KEY);
        done(slots[0]);
        fr(2'd1, w(3'h3, 3'h1, 5'h00));
        chk("key off", ken, 1'b0);
        for (int j = 0; j < 8; j++) begin
            seed = xs(seed);
            s = seed[4:0];
            if (seed[8]) begin
                fr(2'd1, w(3'h3, 3'h0, 5'h00));
                fr(2'd1, w(3'h5, 3'h0, s));
                chk("armed", {armed, busy}, 2'b10);
                fr(2'd2, KEY);
                done(s);
                fr(2'd2, KEY);
                chk("disarmed", {armed, busy}, 2'b00);
            end else begin
                fr(2'd1, w(3'h3, 3'h1, 5'h00));
                fr(2'd1, w(3'h4, 3'h0, s));
                chk("single", {aen, csel}, {1'b0, s});
                dasc_host_model_inst.frame(2'd1, w(3'h4, 3'h0, ~s), 0);
                done(s);
                chk("kept depth", depth, 3'h2);
            end
        end
        complete_run();
    end
endmodule // dasc_seq_ctrl_bench
`default_nettype wire
